// ==== hdl/wrf_core.sv ====
// Purpose: Windowed working registers plus processor control state
// Assumes: Sequencer issues one op per enabled cycle, inputs synchronous
// Notes: Register reads are combinational into registered outputs
`timescale 1ns/100ps
`include "wrf_defs.svh"
module wrf_core
  import wrf_pkg::*;
#(
  parameter logic [3:0] IMPL_ID = 4'h1, // Arbitrary value
  parameter logic [3:0] VER_ID = 4'h2, // Arbitrary value
  parameter bit FPU_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Sequencer command
  input wire wrf_op_type op,
  input wire logic [7:0] op_trap_type,
  input wire logic [31:0] op_data,
  input wire logic [31:0] next_addr,
  input wire logic flags_we,
  input wire logic [3:0] flags_in,
  // Register file port
  input wire logic [4:0] rd_addr,
  input wire logic [4:0] wr_addr,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  // Interrupt source
  input wire logic [3:0] irq_level,
  // Outputs
  output logic [31:0] rd_data,
  output logic [31:0] state_out,
  output logic [31:0] base_out,
  output logic [7:0] mask_out,
  output logic [31:0] partial_out,
  output logic [31:0] pc_out,
  output logic [31:0] npc_out,
  output logic trap_taken,
  output logic halted
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0] globals_r [1:7];
  logic [31:0] win_r [0:`WRF_NREGS-9];
  wrf_regs_type q_r, q_nxt;
  logic [31:0] rd_r;

  logic [2:0] active_window_pointer;
  logic [2:0] cwp_dn, cwp_up;
  logic sup, ten;
  assign active_window_pointer = q_r.state[2:0];
  assign sup = q_r.state[`WRF_PS_SUP];
  assign ten = q_r.state[`WRF_PS_TEN];
  assign cwp_dn = active_window_pointer - 3'd1;
  assign cwp_up = active_window_pointer + 3'd1;

  // Window w: outs at 16w, locals at 16w+8, ins at 16(w+1) mod 128
  function automatic logic [6:0] win_index(input logic [2:0] w, input logic [4:0] a);
    logic [2:0] wn;
    wn = w + 3'd1;
    if (a[4:3] == 2'b01)
      win_index = {w, 4'h0} + {4'h0, a[2:0]};
    else if (a[4:3] == 2'b10)
      win_index = {w, 4'h8} + {4'h0, a[2:0]};
    else
      win_index = {wn, 4'h0} + {4'h0, a[2:0]};
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic take;
  logic [7:0] tt;
  logic irq_ok;
  always_comb begin
    q_nxt = q_r;
    take = 1'b0;
    tt = 8'h00;
    irq_ok = ten && (irq_level > q_r.state[`WRF_PS_PIL_HI -: 4]);
    q_nxt.trap = 1'b0;
    if (q_r.fsm == WRF_ST_RUN) begin
      // Trap decision precedes any state update so a trapping op changes nothing
      case (op)
        WRF_OP_WR_STATE, WRF_OP_WR_MASK, WRF_OP_WR_BASE, WRF_OP_RETURN: begin
          if (!sup) begin
            take = 1'b1;
            tt = `WRF_TT_PRIV;
          end
        end
        WRF_OP_FPU: begin
          if (!q_r.state[`WRF_PS_FPE] || !FPU_PRESENT) begin
            take = 1'b1;
            tt = `WRF_TT_FP_DIS;
          end
        end
        WRF_OP_EXC: begin
          take = 1'b1;
          tt = op_trap_type;
        end
        WRF_OP_SWTRAP: begin
          take = 1'b1;
          tt = `WRF_TT_SW_BASE | {1'b0, op_trap_type[6:0]};
        end
        WRF_OP_PUSH: begin
          if (q_r.mask[cwp_dn]) begin
            take = 1'b1;
            tt = `WRF_TT_WOVF;
          end
        end
        WRF_OP_POP: begin
          if (q_r.mask[cwp_up]) begin
            take = 1'b1;
            tt = `WRF_TT_WUNF;
          end
        end
        default: begin
        end
      endcase
      if (take && (op == WRF_OP_RETURN) && sup && q_r.mask[cwp_up]) begin
        tt = `WRF_TT_WUNF;
      end
      if (!take && op == WRF_OP_RETURN && q_r.mask[cwp_up]) begin
        take = 1'b1;
        tt = `WRF_TT_WUNF;
      end
      if (!take && irq_ok) begin
        take = 1'b1;
        tt = `WRF_TT_INT_BASE | {4'h0, irq_level};
      end
      if (take && !ten && op != WRF_OP_NONE) begin
        q_nxt.fsm = WRF_ST_HALT;
        q_nxt.halted = 1'b1;
      end else if (take) begin
        q_nxt.trap = 1'b1;
        q_nxt.state[`WRF_PS_PSUP] = sup;
        q_nxt.state[`WRF_PS_SUP] = 1'b1;
        q_nxt.state[`WRF_PS_TEN] = 1'b0;
        q_nxt.state[`WRF_PS_CWP_HI:0] = {2'b00, cwp_dn};
        q_nxt.base[11:4] = tt;
        q_nxt.pc = {q_r.base[31:12], tt, 4'h0};
        q_nxt.npc = {q_r.base[31:12], tt, 4'h0} + `WRF_PC_STEP;
      end else begin
        q_nxt.pc = q_r.npc;
        q_nxt.npc = next_addr;
        if (flags_we)
          q_nxt.state[`WRF_PS_ICC_HI -: 4] = flags_in;
        case (op)
          WRF_OP_PUSH: q_nxt.state[`WRF_PS_CWP_HI:0] = {2'b00, cwp_dn};
          WRF_OP_POP: q_nxt.state[`WRF_PS_CWP_HI:0] = {2'b00, cwp_up};
          WRF_OP_RETURN: begin
            q_nxt.state[`WRF_PS_CWP_HI:0] = {2'b00, cwp_up};
            q_nxt.state[`WRF_PS_SUP] = q_r.state[`WRF_PS_PSUP];
            q_nxt.state[`WRF_PS_TEN] = 1'b1;
          end
          WRF_OP_WR_STATE: begin
            q_nxt.state[23:5] = op_data[23:5];
            q_nxt.state[`WRF_PS_CWP_HI:0] = {2'b00, op_data[2:0]};
          end
          WRF_OP_WR_MASK: q_nxt.mask = op_data[7:0];
          WRF_OP_WR_BASE: q_nxt.base[31:12] = op_data[31:12];
          WRF_OP_WR_PARTIAL: q_nxt.partial = op_data;
          default: begin
          end
        endcase
      end
    end
    q_nxt.state[`WRF_PS_IMPL_HI -: 4] = IMPL_ID;
    q_nxt.state[`WRF_PS_VER_HI -: 4] = VER_ID;
    q_nxt.state[19:14] = 6'h00;
    q_nxt.base[3:0] = 4'h0;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Identity bits read fixed from the very first cycle after reset
      q_r.state <= `WRF_PS_RESET | {IMPL_ID, VER_ID, 24'h000000};
      q_r.base <= 32'h00000000;
      q_r.mask <= 8'h00;
      q_r.partial <= 32'h00000000;
      q_r.pc <= `WRF_PC_RESET;
      q_r.npc <= `WRF_PC_STEP;
      q_r.trap <= 1'b0;
      q_r.halted <= 1'b0;
      q_r.fsm <= WRF_ST_RUN;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  // Register file write is squashed by a trap so no visible change occurs
  always_ff @(posedge clk) begin
    if (clk_en && wr_en && !take && q_r.fsm == WRF_ST_RUN) begin
      if (wr_addr[4:3] == 2'b00) begin
        if (wr_addr[2:0] != 3'd0)
          globals_r[wr_addr[2:0]] <= wr_data;
      end else begin
        win_r[win_index(active_window_pointer, wr_addr)] <= wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      rd_r <= 32'h00000000;
    else if (clk_en) begin
      if (rd_addr[4:3] == 2'b00)
        rd_r <= (rd_addr[2:0] == 3'd0) ? 32'h00000000 : globals_r[rd_addr[2:0]];
      else
        rd_r <= win_r[win_index(active_window_pointer, rd_addr)];
    end
  end

  assign rd_data = rd_r;
  assign state_out = q_r.state;
  assign base_out = q_r.base;
  assign mask_out = q_r.mask;
  assign partial_out = q_r.partial;
  assign pc_out = q_r.pc;
  assign npc_out = q_r.npc;
  assign trap_taken = q_r.trap;
  assign halted = q_r.halted;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  trap_clears_ten_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(q_r.trap) |-> !q_r.state[`WRF_PS_TEN]) else $error("trap left enable set");
  trap_sets_sup_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(q_r.trap) |-> q_r.state[`WRF_PS_SUP] && (q_r.state[`WRF_PS_PSUP] == $past(sup)))
    else $error("trap mode bits wrong");
  trap_cwp_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && take && ten && q_r.fsm == WRF_ST_RUN |=> q_r.state[2:0] == $past(cwp_dn))
    else $error("trap did not decrement window");
  trap_vector_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(q_r.trap) |-> q_r.pc == {q_r.base[31:4], 4'h0}) else $error("trap vector wrong");
  irq_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && op == WRF_OP_NONE && (irq_level <= q_r.state[11:8]) && q_r.fsm == WRF_ST_RUN |-> !take)
    else $error("interrupt taken at or below threshold");
  ident_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 q_r.state[31:24] == {IMPL_ID, VER_ID}) else $error("identity field changed");
  push_ovf_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && ten && q_r.fsm == WRF_ST_RUN && op == WRF_OP_PUSH && q_r.mask[cwp_dn]
    |=> q_r.trap && q_r.base[11:4] == `WRF_TT_WOVF)
    else $error("overflow trap missed");
  base_low_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 q_r.base[3:0] == 4'h0) else $error("base low bits nonzero");
  pc_advance_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && !take && q_r.fsm == WRF_ST_RUN |=> q_r.pc == $past(q_r.npc))
    else $error("pc did not take next pc");

  // ----------------------------------------
  // Window, trap, flag, partial product and read-path checks
  // ----------------------------------------
  push_moves_win_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && q_r.fsm == WRF_ST_RUN && op == WRF_OP_PUSH && !take
    |=> q_r.state[2:0] == $past(cwp_dn)) else $error("push did not move window down");
  pop_moves_win_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && q_r.fsm == WRF_ST_RUN && op == WRF_OP_POP && !take
    |=> q_r.state[2:0] == $past(cwp_up)) else $error("pop did not move window up");
  window_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && q_r.fsm == WRF_ST_RUN && op inside {WRF_OP_POP, WRF_OP_RETURN} && !take && active_window_pointer == 3'd7
    |=> q_r.state[2:0] == 3'd0) else $error("window pointer did not wrap");
  return_restore_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && q_r.fsm == WRF_ST_RUN && op == WRF_OP_RETURN && !take
    |=> q_r.state[`WRF_PS_TEN] && q_r.state[`WRF_PS_SUP] == $past(q_r.state[`WRF_PS_PSUP]))
    else $error("return did not restore mode");
  pop_unf_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && ten && q_r.fsm == WRF_ST_RUN && op == WRF_OP_POP && q_r.mask[cwp_up]
    |=> q_r.trap && q_r.base[11:4] == `WRF_TT_WUNF) else $error("underflow trap missed");
  priv_trap_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && ten && !sup && q_r.fsm == WRF_ST_RUN && op inside {WRF_OP_WR_STATE, WRF_OP_WR_MASK,
      WRF_OP_WR_BASE, WRF_OP_RETURN} |=> q_r.trap && q_r.base[11:4] == `WRF_TT_PRIV)
    else $error("privileged op ran in user mode");
  fpu_off_trap_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && ten && q_r.fsm == WRF_ST_RUN && op == WRF_OP_FPU && !q_r.state[`WRF_PS_FPE]
    |=> q_r.trap && q_r.base[11:4] == `WRF_TT_FP_DIS) else $error("disabled fpu op did not trap");
  sw_trap_high_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && ten && q_r.fsm == WRF_ST_RUN && op == WRF_OP_SWTRAP
    |=> q_r.trap && q_r.base[11:4] == {1'b1, $past(op_trap_type[6:0])}) else $error("software trap type wrong");
  irq_type_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && ten && q_r.fsm == WRF_ST_RUN && op == WRF_OP_NONE && irq_level > q_r.state[11:8]
    |=> q_r.trap && q_r.base[11:4] == {4'h1, $past(irq_level)}) else $error("interrupt trap type wrong");
  irq_masked_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && q_r.fsm == WRF_ST_RUN && !ten && op == WRF_OP_NONE |-> !take) else $error("interrupt taken with traps off");
  halt_on_exc_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && !ten && q_r.fsm == WRF_ST_RUN && op == WRF_OP_EXC
    |=> q_r.halted && !q_r.trap) else $error("exception with traps off did not halt");
  halt_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && q_r.halted |=> q_r.halted && q_r.pc == $past(q_r.pc)) else $error("halted block moved on");
  trap_no_change_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && take && ten && q_r.fsm == WRF_ST_RUN
    |=> q_r.partial == $past(q_r.partial) && q_r.mask == $past(q_r.mask)
      && q_r.state[23:20] == $past(q_r.state[23:20])) else $error("trapping op changed state");
  flags_update_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && q_r.fsm == WRF_ST_RUN && !take && flags_we && op != WRF_OP_WR_STATE
    |=> q_r.state[23:20] == $past(flags_in)) else $error("condition flags not written");
  global_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && rd_addr == 5'd0 |=> rd_r == 32'h00000000) else $error("global zero read nonzero");
  partial_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && reset_n && q_r.fsm == WRF_ST_RUN && op == WRF_OP_WR_PARTIAL && !take
    |=> q_r.partial == $past(op_data)) else $error("partial product not held");
endmodule // wrf_core

// ==== hdl/wrf_defs.svh ====
// Purpose: Constants for the windowed register file and trap state block
// Assumes: 32-bit data, eight windows
// Notes: Field positions, reset values and trap codes as macros
//
// Notes on behaviour
// - 136 registers, eight globals always visible
// - Eight windows of ins, outs, locals
// - Outs of one window are next ins
// - Window 0 outs wrap to window 7 ins
// - Pointer down on trap/push, up on pop/return
// - Bits 31:28 impl, 27:24 version, fixed
// - Bits 23:20 hold N Z V C flags
// - Bit 12 enables FPU; else FP traps
// - Interrupt accepted only above threshold bits 11:8
// - Bit 7 one means supervisor mode
// - Trap copies supervisor bit into bit 6
// - Bit 5 gates traps; trap clears it
// - Traps disabled: ignore interrupts, exception halts
// - State register written only by privileged access
// - Move onto invalid window raises window trap
// - Base 31:12, type 11:4, low bits zero
// - 128 hardware and 128 software trap entries
// - Trap jumps to base plus type offset
// - Trap taken before any visible change
// - Separate partial product register for multiply step
// - Current and next program counters kept
// - Privileged ops only in supervisor mode
`ifndef WRF_DEFS_SVH
`define WRF_DEFS_SVH
`define WRF_NWIN 8
`define WRF_NREGS 136
`define WRF_PS_IMPL_HI 31
`define WRF_PS_VER_HI 27
`define WRF_PS_ICC_HI 23
`define WRF_PS_CPE 13
`define WRF_PS_FPE 12
`define WRF_PS_PIL_HI 11
`define WRF_PS_SUP 7
`define WRF_PS_PSUP 6
`define WRF_PS_TEN 5
`define WRF_PS_CWP_HI 4
`define WRF_PS_RESET 32'h000000E0
`define WRF_TT_FP_DIS 8'h04
`define WRF_TT_PRIV 8'h03
`define WRF_TT_WOVF 8'h05
`define WRF_TT_WUNF 8'h06
`define WRF_TT_INT_BASE 8'h10
`define WRF_TT_SW_BASE 8'h80
`define WRF_PC_RESET 32'h00000000
`define WRF_PC_STEP 32'h00000004
`endif

// ==== hdl/wrf_pkg.sv ====
// Purpose: Types for the windowed register file and trap state block
// Assumes: wrf_defs.svh supplies the numbers
// Notes: Command codes of the sequencer port
package wrf_pkg;
  typedef enum logic [3:0] {
    WRF_OP_NONE = 4'h0, WRF_OP_PUSH = 4'h1, WRF_OP_POP = 4'h2, WRF_OP_RETURN = 4'h3,
    WRF_OP_SWTRAP = 4'h4, WRF_OP_WR_STATE = 4'h5, WRF_OP_WR_MASK = 4'h6, WRF_OP_WR_BASE = 4'h7,
    WRF_OP_FPU = 4'h8, WRF_OP_EXC = 4'h9, WRF_OP_WR_PARTIAL = 4'hA
  } wrf_op_type;
  typedef enum logic [1:0] {
    WRF_ST_RUN = 2'b01, WRF_ST_HALT = 2'b10
  } wrf_state_type;
  typedef struct packed {
    logic [31:0] state;
    logic [31:0] base;
    logic [7:0] mask;
    logic [31:0] partial;
    logic [31:0] pc;
    logic [31:0] npc;
    logic trap;
    logic halted;
    wrf_state_type fsm;
  } wrf_regs_type;
endpackage

// ==== verification/wrf_irq_source.sv ====
// Purpose: Interrupt controller model facing the register file block
// Assumes: Bench picks the pending level; zero means no request
// Notes: Request drops once its interrupt trap has been taken
`timescale 1ns/100ps
module wrf_irq_source (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Request and acknowledge
  input wire logic [3:0] want,
  input wire logic trap_taken,
  input wire logic [31:0] base_out,
  // Level to the block
  output logic [3:0] irq_level
);
  logic acked_r;
  // Held until serviced, like a level source that software clears
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) acked_r <= 1'b0;
    else if (want == 4'h0) acked_r <= 1'b0;
    else if (trap_taken && base_out[11:4] == (8'h10 + {4'h0, want})) acked_r <= 1'b1;
  end
  assign irq_level = acked_r ? 4'h0 : want;
endmodule // wrf_irq_source

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the windowed register file block
// Assumes: Reference model of state kept in the driver
// Notes: pc is judged on traps only, npc on non-trapping non-idle ops
`timescale 1ns/100ps
module testbench;
  import wrf_pkg::*;
  typedef struct packed {
    logic [31:0] st, bs, pc, np, rd, pp, due;
    logic tr, hl, cn, cr;
    logic [7:0] mk;
  } wrf_note_type;
  logic clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, flags_we = 1'b0, trap_taken, halted, eh = 1'b0;
  wrf_op_type op = WRF_OP_NONE;
  logic [7:0] op_trap_type = 8'h00, mask_out, em = 8'h00;
  logic [31:0] op_data = 32'h0, next_addr = 32'h0, wr_data = 32'h0, rd_data, state_out, base_out;
  logic [31:0] partial_out, pc_out, npc_out, a, b, rx = 32'h0;
  logic [31:0] es = 32'h120000E0, eb = 32'h0, ep = 32'h0;
  logic [3:0] flags_in = 4'h0, want = 4'h0, irq_level;
  logic [4:0] rd_addr = 5'h0, wr_addr = 5'h0;
  int fail_count = 0, check_count = 0, seed = 97265, cyc = 0;
  wrf_note_type q[$];
  wrf_note_type n;
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  wrf_irq_source wrf_irq_source_i (.clk(clk), .reset_n(reset_n), .want(want), .trap_taken(trap_taken),
    .base_out(base_out), .irq_level(irq_level));
  wrf_core #(.IMPL_ID(4'h1), .VER_ID(4'h2), .FPU_PRESENT(1'b1)) wrf_core_i (.clk(clk), .reset_n(reset_n),
    .clk_en(1'b1), .op(op), .op_trap_type(op_trap_type), .op_data(op_data), .next_addr(next_addr),
    .flags_we(flags_we), .flags_in(flags_in), .rd_addr(rd_addr), .wr_addr(wr_addr), .wr_en(wr_en),
    .wr_data(wr_data), .irq_level(irq_level), .rd_data(rd_data), .state_out(state_out), .base_out(base_out),
    .mask_out(mask_out), .partial_out(partial_out), .pc_out(pc_out), .npc_out(npc_out),
    .trap_taken(trap_taken), .halted(halted));
  // ----------------------------------------
  // Comparison and verdict
  // ----------------------------------------
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge clk) begin
    while (q.size() > 0 && q[0].due == cyc) begin
      n = q.pop_front();
      check("state", state_out, n.st);
      check("base", base_out, n.bs);
      check("partial", partial_out, n.pp);
      check("mask", {24'h0, mask_out}, {24'h0, n.mk});
      check("trap", {31'h0, trap_taken}, {31'h0, n.tr});
      check("halt", {31'h0, halted}, {31'h0, n.hl});
      if (n.tr) check("pc", pc_out, n.pc);
      if (n.cn) check("npc", npc_out, n.np);
      if (n.cr) check("rd", rd_data, n.rd);
    end
  end
  // ----------------------------------------
  // Driver with reference model
  // ----------------------------------------
  task op_t(input wrf_op_type o, input logic [31:0] d, input logic [3:0] irq = 4'h0,
      input logic [5:0] w = 6'h0, input logic [5:0] r = 6'h0, input logic f = 1'b0);
    logic [7:0] t;
    logic [2:0] cw;
    wrf_note_type e;
    t = 8'h00;
    cw = es[2:0];
    e.np = $random(seed);
    if ((o == WRF_OP_RETURN || o == WRF_OP_WR_STATE || o == WRF_OP_WR_MASK || o == WRF_OP_WR_BASE) && !es[7])
      t = 8'h03;
    else case (o)
      WRF_OP_PUSH: if (em[cw - 3'd1]) t = 8'h05; else cw = cw - 3'd1;
      WRF_OP_POP, WRF_OP_RETURN: if (em[cw + 3'd1]) t = 8'h06; else cw = cw + 3'd1;
      WRF_OP_SWTRAP: t = 8'h80 | d[7:0];
      WRF_OP_FPU: if (!es[12]) t = 8'h04;
      WRF_OP_EXC: t = d[7:0];
      WRF_OP_NONE: if (es[5] && irq > es[11:8]) t = 8'h10 + {4'h0, irq};
      default: ;
    endcase
    e.tr = 1'b0;
    e.cn = 1'b0;
    if (eh) ;
    else if (t != 8'h00 && !es[5]) eh = 1'b1;
    else if (t != 8'h00) begin
      es[6] = es[7];
      es[7] = 1'b1;
      es[5] = 1'b0;
      es[2:0] = es[2:0] - 3'd1;
      eb[11:4] = t;
      e.tr = 1'b1;
    end else begin
      es[2:0] = cw;
      e.cn = (o != WRF_OP_NONE);
      if (o == WRF_OP_RETURN) es[7] = es[6];
      if (o == WRF_OP_RETURN) es[5] = 1'b1;
      if (o == WRF_OP_WR_STATE) es[23:0] = {d[23:5], 2'b00, d[2:0]};
      if (o == WRF_OP_WR_MASK) em = d[7:0];
      if (o == WRF_OP_WR_BASE) eb[31:12] = d[31:12];
      if (o == WRF_OP_WR_PARTIAL) ep = d;
      if (f) es[23:20] = d[23:20];
    end
    {e.st, e.bs, e.pc, e.pp, e.rd, e.cr, e.hl} = {es, eb, eb[31:12], t, 4'h0, ep, rx, r[5], eh};
    e.mk = em;
    @(posedge clk);
    {op, op_data, op_trap_type, next_addr, want, flags_we, flags_in} <= {o, d, d[7:0], e.np, irq, f, d[23:20]};
    {wr_en, wr_addr, wr_data, rd_addr} <= {w, d, r[4:0]};
    // Sampled one edge after it is driven, result visible after that edge
    e.due = cyc + 2;
    q.push_back(e);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    a = $random(seed);
    b = $random(seed);
    op_t(WRF_OP_WR_BASE, 32'hABCDE000);
    op_t(WRF_OP_WR_PARTIAL, b);
    op_t(WRF_OP_NONE, a, 4'h0, 6'h00, 6'h00, 1'b1);
    op_t(WRF_OP_NONE, a, 4'h0, 6'h21);
    op_t(WRF_OP_NONE, b, 4'h0, 6'h28);
    op_t(WRF_OP_NONE, b, 4'h0, 6'h20);
    op_t(WRF_OP_PUSH, 32'h0);
    rx = b;
    op_t(WRF_OP_NONE, 32'h0, 4'h0, 6'h00, 6'h38);
    rx = a;
    op_t(WRF_OP_NONE, 32'h0, 4'h0, 6'h00, 6'h21);
    rx = 32'h0;
    op_t(WRF_OP_NONE, 32'h0, 4'h0, 6'h00, 6'h20);
    for (int i = 0; i < 7; i++) op_t(WRF_OP_PUSH, 32'h0);
    op_t(WRF_OP_WR_MASK, 32'h80);
    op_t(WRF_OP_NONE, a, 4'h0, 6'h22);
    op_t(WRF_OP_PUSH, b, 4'h0, 6'h22);
    rx = a;
    op_t(WRF_OP_NONE, 32'h0, 4'h0, 6'h00, 6'h22);
    op_t(WRF_OP_RETURN, 32'h0);
    op_t(WRF_OP_WR_MASK, 32'h02);
    op_t(WRF_OP_POP, 32'h0);
    op_t(WRF_OP_RETURN, 32'h0);
    op_t(WRF_OP_WR_STATE, 32'h000005E0);
    for (int i = 0; i < 16; i++) begin
      op_t(WRF_OP_NONE, 32'h0, i[3:0]);
      if (i > 5) op_t(WRF_OP_NONE, 32'h0, i[3:0]);
      if (i > 5) op_t(WRF_OP_RETURN, 32'h0);
    end
    op_t(WRF_OP_FPU, 32'h0);
    op_t(WRF_OP_RETURN, 32'h0);
    // User mode with the coprocessor bit left clear
    op_t(WRF_OP_WR_STATE, 32'h00001020);
    op_t(WRF_OP_FPU, 32'h0);
    op_t(WRF_OP_WR_MASK, 32'h0);
    op_t(WRF_OP_RETURN, 32'h0);
    op_t(WRF_OP_SWTRAP, a & 32'h7F);
    op_t(WRF_OP_RETURN, 32'h0);
    op_t(WRF_OP_RETURN, 32'h0);
    op_t(WRF_OP_RETURN, 32'h0);
    op_t(WRF_OP_EXC, 32'h09);
    op_t(WRF_OP_EXC, 32'h09);
    op_t(WRF_OP_PUSH, 32'h0);
    repeat (2) @(posedge clk);
    summarize();
  end
  // About 75 ops are issued; this bound is well beyond that
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule // testbench
